// File: hw/dscg_pkg.sv
// Purpose: shared constants and carriers for the deep-sleep clock gating block
// Assumes: single 100 MHz clock, plain register port
// Notes: all offsets are byte addresses
package dscg_pkg;
   // ==========================================================
   // register map
   localparam logic [11:0] RUN_GATE_OFS = 12'h100;
   localparam logic [11:0] SLEEP_GATE_OFS = 12'h110;
   localparam logic [11:0] DEEP_GATE_OFS = 12'h120;
   localparam logic [11:0] RUN_CFG_OFS = 12'h060;
   localparam logic [11:0] IRQ_STAT_OFS = 12'h1F0;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h1F4;
   localparam logic [11:0] PWR_STATE_OFS = 12'h1F8;
   // ==========================================================
   // field layout of the gating registers and the auto gating bit of the run config
   localparam int CAN_BIT = 24;
   localparam int PWM_BIT = 20;
   localparam int ADC_BIT = 16;
   localparam int RATE_HI = 11;
   localparam int RATE_LO = 8;
   localparam int HIB_BIT = 6;
   localparam int WDT_BIT = 3;
   localparam int ACG_BIT = 27;
   localparam logic [31:0] GATE_WMASK = 32'h01110F48;
   localparam logic [31:0] RUN_GATE_RST = 32'h00000040;
   localparam logic [31:0] SLEEP_GATE_RST = 32'h00000040;
   localparam logic [31:0] DEEP_GATE_RST = 32'h00000040;
   localparam logic [31:0] RUN_CFG_RST = 32'h00000000;
   localparam logic [3:0] RATE_MAX = 4'h2;
   // ==========================================================
   // units and events
   localparam int NUM_UNITS = 5;
   localparam int U_WDT = 0;
   localparam int U_HIB = 1;
   localparam int U_ADC = 2;
   localparam int U_PWM = 3;
   localparam int U_CAN = 4;
   localparam int NUM_EVT = 2;
   localparam int EVT_FAULT = 0;
   localparam int EVT_CLAMP = 1;
   typedef enum logic [1:0] {
      PS_RUN = 2'b00,
      PS_SLEEP = 2'b01,
      PS_DEEP = 2'b10
   } dscg_pstate_e;
   typedef struct packed {
      logic [NUM_UNITS-1:0] en;
      logic [3:0] rate;
   } dscg_gates_s;
endpackage : dscg_pkg

// File: hw/dscg_select.sv
// Purpose: picks the active gating set and applies it one clock edge later
// Assumes: power state changes are synchronous to mclk_i
// Notes: enables only change on a clock edge, so gated units see no glitch
`timescale 1ns/1ps
`default_nettype none
module dscg_select (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [1:0] pstate_i,
   input wire logic acg_i,
   input wire dscg_pkg::dscg_gates_s run_i,
   input wire dscg_pkg::dscg_gates_s sleep_i,
   input wire dscg_pkg::dscg_gates_s deep_i,
   output var dscg_pkg::dscg_gates_s gates_o
);
   // ==========================================================
   // selection: without auto gating the run set rules every state
   wire use_sleep = acg_i && (pstate_i == dscg_pkg::PS_SLEEP);
   wire use_deep = acg_i && (pstate_i == dscg_pkg::PS_DEEP);
   dscg_pkg::dscg_gates_s sel_w;
   assign sel_w = use_deep ? deep_i : (use_sleep ? sleep_i : run_i);
   dscg_pkg::dscg_gates_s gates_q;
   // registered so a set switch is one clean edge
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         gates_q <= '0;
      end else begin
         gates_q <= sel_w;
      end
   end
   assign gates_o = gates_q;
endmodule : dscg_select
`default_nettype wire

// File: hw/dscg_fault.sv
// Purpose: answers unit accesses with ok or bus fault from the live enables
// Assumes: one access strobe per cycle per unit
// Notes: fault pulse is registered, one cycle after the access
`timescale 1ns/1ps
`default_nettype none
module dscg_fault #(
   parameter int N = 5
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [N-1:0] en_i,
   input wire logic [N-1:0] acc_i,
   output logic [N-1:0] done_o,
   output logic [N-1:0] fault_o
);
   logic [N-1:0] done_q;
   logic [N-1:0] fault_q;
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_unit
         always_ff @(posedge mclk_i) begin
            if (sys_rst_i) begin
               done_q[g] <= 1'b0;
               fault_q[g] <= 1'b0;
            end else begin
               done_q[g] <= acc_i[g] && en_i[g];
               fault_q[g] <= acc_i[g] && !en_i[g];
            end
         end
      end
   endgenerate
   assign done_o = done_q;
   assign fault_o = fault_q;
endmodule : dscg_fault
`default_nettype wire

// File: hw/dscg_top.sv
// Purpose: deep-sleep clock gating control with run and sleep sets beside it
// Assumes: register port with read data one cycle after the read strobe
// Notes: unit order in vectors is watchdog, hibernate, adc, pwm, can
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - rate field bits 11:8: 2,1,0 codes
// - rate writes above maximum are clamped
// - bit 6 clocks the hibernate unit
// - bit 3 clocks watchdog; unclocked access faults
// - each gate bit is one unit enable
// - access to any unclocked unit faults
// - deep-sleep gating register resets to 0x40
// - sleep sets apply only with auto gating
// - can bit 24, pwm 20, adc 16
// - reserved bits read zero, ignore writes
module dscg_top (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic [1:0] pstate_i,
   input wire logic [4:0] unit_acc_i,
   output logic [4:0] unit_done_o,
   output logic [4:0] unit_fault_o,
   output logic [4:0] unit_clk_en_o,
   output logic [3:0] adc_rate_limit_o,
   output logic irq_o
);
   // ==========================================================
   // address decode
   wire hit_run = reg_addr_i == dscg_pkg::RUN_GATE_OFS;
   wire hit_sleep = reg_addr_i == dscg_pkg::SLEEP_GATE_OFS;
   wire hit_deep = reg_addr_i == dscg_pkg::DEEP_GATE_OFS;
   wire hit_cfg = reg_addr_i == dscg_pkg::RUN_CFG_OFS;
   wire hit_stat = reg_addr_i == dscg_pkg::IRQ_STAT_OFS;
   wire hit_mask = reg_addr_i == dscg_pkg::IRQ_MASK_OFS;
   wire hit_ps = reg_addr_i == dscg_pkg::PWR_STATE_OFS;

   // ==========================================================
   // gating write path
   // reserved bits dropped on write so they always read zero
   wire [31:0] wmask_w = reg_wdata_i & dscg_pkg::GATE_WMASK;
   wire [3:0] wrate_w = reg_wdata_i[dscg_pkg::RATE_HI:dscg_pkg::RATE_LO];
   wire rate_over_w = wrate_w > dscg_pkg::RATE_MAX;
   // clamp instead of rejecting: keeps the rest of the write intact
   wire [3:0] crate_w = rate_over_w ? dscg_pkg::RATE_MAX : wrate_w;
   wire [31:0] wgate_w = {wmask_w[31:12], crate_w, wmask_w[7:0]};

   logic [31:0] run_q;
   logic [31:0] sleep_q;
   logic [31:0] deep_q;
   logic [31:0] cfg_q;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         run_q <= dscg_pkg::RUN_GATE_RST;
         sleep_q <= dscg_pkg::SLEEP_GATE_RST;
         deep_q <= dscg_pkg::DEEP_GATE_RST;
         cfg_q <= dscg_pkg::RUN_CFG_RST;
      end else if (reg_wr_i) begin
         if (hit_run) run_q <= wgate_w;
         if (hit_sleep) sleep_q <= wgate_w;
         if (hit_deep) deep_q <= wgate_w;
         if (hit_cfg) cfg_q <= reg_wdata_i & (32'h1 << dscg_pkg::ACG_BIT);
      end
   end

   // ==========================================================
   // unpack sets into enables
   function automatic dscg_pkg::dscg_gates_s unpack(input logic [31:0] r);
      dscg_pkg::dscg_gates_s s;
      s.en[dscg_pkg::U_WDT] = r[dscg_pkg::WDT_BIT];
      s.en[dscg_pkg::U_HIB] = r[dscg_pkg::HIB_BIT];
      s.en[dscg_pkg::U_ADC] = r[dscg_pkg::ADC_BIT];
      s.en[dscg_pkg::U_PWM] = r[dscg_pkg::PWM_BIT];
      s.en[dscg_pkg::U_CAN] = r[dscg_pkg::CAN_BIT];
      s.rate = r[dscg_pkg::RATE_HI:dscg_pkg::RATE_LO];
      return s;
   endfunction : unpack

   dscg_pkg::dscg_gates_s gates_w;
   wire acg_w = cfg_q[dscg_pkg::ACG_BIT];
   dscg_select u_sel (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .pstate_i(pstate_i),
      .acg_i(acg_w),
      .run_i(unpack(run_q)),
      .sleep_i(unpack(sleep_q)),
      .deep_i(unpack(deep_q)),
      .gates_o(gates_w)
   );
   assign unit_clk_en_o = gates_w.en;
   assign adc_rate_limit_o = gates_w.rate;

   // ==========================================================
   // bus fault for unclocked units
   logic [4:0] fault_w;
   dscg_fault #(
      .N(dscg_pkg::NUM_UNITS)
   ) u_fault (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .en_i(gates_w.en),
      .acc_i(unit_acc_i),
      .done_o(unit_done_o),
      .fault_o(fault_w)
   );
   assign unit_fault_o = fault_w;

   // ==========================================================
   // interrupts: set wins over write-one-to-clear
   wire [1:0] evt_w = {reg_wr_i && (hit_run || hit_sleep || hit_deep) && rate_over_w, |fault_w};
   logic [1:0] stat_q;
   logic [1:0] mask_q;
   wire [1:0] clr_w = (reg_wr_i && hit_stat) ? reg_wdata_i[1:0] : 2'b00;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         stat_q <= 2'h0;
         mask_q <= 2'h0;
      end else begin
         stat_q <= (stat_q & ~clr_w) | evt_w;
         if (reg_wr_i && hit_mask) mask_q <= reg_wdata_i[1:0];
      end
   end
   assign irq_o = |(stat_q & mask_q);

   // ==========================================================
   // read path
   logic [31:0] rmux_w;
   assign rmux_w = hit_run ? run_q :
                   hit_sleep ? sleep_q :
                   hit_deep ? deep_q :
                   hit_cfg ? cfg_q :
                   hit_stat ? {30'h0, stat_q} :
                   hit_mask ? {30'h0, mask_q} :
                   hit_ps ? {30'h0, pstate_i} : 32'h0;
   logic [31:0] rdata_q;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= reg_rd_i ? rmux_w : 32'h0;
      end
   end
   assign reg_rdata_o = rdata_q;

   // ==========================================================
   // checks
   property p_rate_clamp;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit_deep) |=> deep_q[11:8] <= 4'h2;
   endproperty
   a_rate_clamp: assert property (p_rate_clamp) else $error("rate above max");
   property p_rsv_zero;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (deep_q & ~dscg_pkg::GATE_WMASK) == 32'h0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");
   property p_fault;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (unit_acc_i[0] && !unit_clk_en_o[0]) |=> unit_fault_o[0] && !unit_done_o[0];
   endproperty
   a_fault: assert property (p_fault) else $error("no fault on gated wdt");
   property p_ok;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (unit_acc_i[4] && unit_clk_en_o[4]) |=> unit_done_o[4] && !unit_fault_o[4];
   endproperty
   a_ok: assert property (p_ok) else $error("clocked access faulted");
   property p_deep_sel;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (acg_w && pstate_i == 2'b10) |=> unit_clk_en_o[1] == $past(deep_q[6]);
   endproperty
   a_deep_sel: assert property (p_deep_sel) else $error("deep set not applied");
   property p_run_sel;
      @(posedge mclk_i) disable iff (sys_rst_i)
      !acg_w |=> unit_clk_en_o[2] == $past(run_q[16]);
   endproperty
   a_run_sel: assert property (p_run_sel) else $error("run set not applied");
   property p_rst;
      @(posedge mclk_i) sys_rst_i |=> deep_q == 32'h00000040;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset value");
   property p_irq;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (|fault_w && mask_q[0] && !(reg_wr_i && hit_mask)) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

   // ==========================================================
   // register contents, unit answers and read port
   property p_run_rsv;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (run_q & ~dscg_pkg::GATE_WMASK) == 32'h0;
   endproperty
   a_run_rsv: assert property (p_run_rsv) else $error("reserved run bit set");
   property p_sleep_rsv;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (sleep_q & ~dscg_pkg::GATE_WMASK) == 32'h0;
   endproperty
   a_sleep_rsv: assert property (p_sleep_rsv) else $error("reserved sleep bit set");
   property p_cfg_rsv;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (cfg_q & ~(32'h1 << dscg_pkg::ACG_BIT)) == 32'h0;
   endproperty
   a_cfg_rsv: assert property (p_cfg_rsv) else $error("config holds more than auto gating");
   property p_run_rate;
      @(posedge mclk_i) disable iff (sys_rst_i)
      run_q[dscg_pkg::RATE_HI:dscg_pkg::RATE_LO] <= dscg_pkg::RATE_MAX;
   endproperty
   a_run_rate: assert property (p_run_rate) else $error("run rate above max");
   property p_sleep_rate;
      @(posedge mclk_i) disable iff (sys_rst_i)
      sleep_q[dscg_pkg::RATE_HI:dscg_pkg::RATE_LO] <= dscg_pkg::RATE_MAX;
   endproperty
   a_sleep_rate: assert property (p_sleep_rate) else $error("sleep rate above max");
   property p_out_rate;
      @(posedge mclk_i) disable iff (sys_rst_i)
      adc_rate_limit_o <= dscg_pkg::RATE_MAX;
   endproperty
   a_out_rate: assert property (p_out_rate) else $error("applied rate above max");
   property p_rate_keep;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit_deep && !rate_over_w) |=> deep_q[dscg_pkg::RATE_HI:dscg_pkg::RATE_LO] == $past(wrate_w);
   endproperty
   a_rate_keep: assert property (p_rate_keep) else $error("legal rate not stored");
   property p_run_clamp;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit_run && rate_over_w) |=> run_q[dscg_pkg::RATE_HI:dscg_pkg::RATE_LO] == dscg_pkg::RATE_MAX;
   endproperty
   a_run_clamp: assert property (p_run_clamp) else $error("rate not clamped to max");
   property p_deep_hold;
      @(posedge mclk_i) disable iff (sys_rst_i)
      !(reg_wr_i && hit_deep) |=> $stable(deep_q);
   endproperty
   a_deep_hold: assert property (p_deep_hold) else $error("deep set changed without write");
   property p_deep_hi;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit_deep) |=> deep_q[dscg_pkg::CAN_BIT] == $past(reg_wdata_i[dscg_pkg::CAN_BIT])
         && deep_q[dscg_pkg::PWM_BIT] == $past(reg_wdata_i[dscg_pkg::PWM_BIT])
         && deep_q[dscg_pkg::ADC_BIT] == $past(reg_wdata_i[dscg_pkg::ADC_BIT]);
   endproperty
   a_deep_hi: assert property (p_deep_hi) else $error("upper gate bit not written");
   property p_deep_lo;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit_deep) |=> deep_q[dscg_pkg::HIB_BIT] == $past(reg_wdata_i[dscg_pkg::HIB_BIT])
         && deep_q[dscg_pkg::WDT_BIT] == $past(reg_wdata_i[dscg_pkg::WDT_BIT]);
   endproperty
   a_deep_lo: assert property (p_deep_lo) else $error("lower gate bit not written");
   property p_sleep_sel;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (acg_w && pstate_i == dscg_pkg::PS_SLEEP) |=>
         unit_clk_en_o[dscg_pkg::U_PWM] == $past(sleep_q[dscg_pkg::PWM_BIT]);
   endproperty
   a_sleep_sel: assert property (p_sleep_sel) else $error("sleep set not applied");
   property p_rate_sel;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (acg_w && pstate_i == dscg_pkg::PS_DEEP) |=>
         adc_rate_limit_o == $past(deep_q[dscg_pkg::RATE_HI:dscg_pkg::RATE_LO]);
   endproperty
   a_rate_sel: assert property (p_rate_sel) else $error("deep rate not applied");
   property p_fault_vec;
      @(posedge mclk_i) disable iff (sys_rst_i)
      1'b1 |=> unit_fault_o == ($past(unit_acc_i) & ~$past(unit_clk_en_o));
   endproperty
   a_fault_vec: assert property (p_fault_vec) else $error("fault vector wrong");
   property p_done_vec;
      @(posedge mclk_i) disable iff (sys_rst_i)
      1'b1 |=> unit_done_o == ($past(unit_acc_i) & $past(unit_clk_en_o));
   endproperty
   a_done_vec: assert property (p_done_vec) else $error("done vector wrong");
   property p_evt_fault;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (|fault_w) |=> stat_q[dscg_pkg::EVT_FAULT];
   endproperty
   a_evt_fault: assert property (p_evt_fault) else $error("fault not flagged");
   property p_evt_clamp;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wr_i && (hit_run || hit_sleep || hit_deep) && rate_over_w) |=> stat_q[dscg_pkg::EVT_CLAMP];
   endproperty
   a_evt_clamp: assert property (p_evt_clamp) else $error("clamp not flagged");
   property p_stat_clr;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit_stat && reg_wdata_i[dscg_pkg::EVT_FAULT] && !(|fault_w)) |=> !stat_q[dscg_pkg::EVT_FAULT];
   endproperty
   a_stat_clr: assert property (p_stat_clr) else $error("fault flag not cleared");
   property p_rd_idle;
      @(posedge mclk_i) disable iff (sys_rst_i)
      !reg_rd_i |=> reg_rdata_o == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_rd_deep;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_rd_i && hit_deep) |=> reg_rdata_o == $past(deep_q);
   endproperty
   a_rd_deep: assert property (p_rd_deep) else $error("deep set read wrong");
   property p_rd_stat;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_rd_i && hit_stat) |=> reg_rdata_o == {30'h0, $past(stat_q)};
   endproperty
   a_rd_stat: assert property (p_rd_stat) else $error("status read wrong");
   property p_mask_wr;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit_mask) |=> mask_q == $past(reg_wdata_i[1:0]);
   endproperty
   a_mask_wr: assert property (p_mask_wr) else $error("mask not written");
endmodule : dscg_top
`default_nettype wire

// File: tb/dscg_top_tb.sv
// Purpose: self-checking bench for the deep-sleep clock gating block
// Assumes: read data stand only in the cycle after the read strobe
// Notes: directed stimulus only; unit vector order wdt, hib, adc, pwm, can
`timescale 1ns/1ps
`default_nettype none
module dscg_top_tb;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [11:0] reg_addr_i = 12'h000;
   logic [31:0] reg_wdata_i = 32'h00000000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [1:0] pstate_i = 2'h0;
   logic [4:0] unit_acc_i = 5'h00;
   logic [31:0] reg_rdata_o;
   logic [4:0] unit_done_o;
   logic [4:0] unit_fault_o;
   logic [4:0] unit_clk_en_o;
   logic [3:0] adc_rate_limit_o;
   logic irq_o;
   int failures = 0;
   int comparisons = 0;
   // ==========================================================
   // clock and design
   always #5 mclk_i = ~mclk_i;
   dscg_top dscg_top_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .pstate_i(pstate_i), .unit_acc_i(unit_acc_i), .unit_done_o(unit_done_o),
      .unit_fault_o(unit_fault_o), .unit_clk_en_o(unit_clk_en_o),
      .adc_rate_limit_o(adc_rate_limit_o), .irq_o(irq_o));
   // ==========================================================
   // access tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(reg_rdata_o, exp);
   endtask : rd
   // one pulse on the units in a, all expected to fault or all to finish
   task automatic acc(input logic [4:0] a, input logic flt);
      @(posedge mclk_i);
      unit_acc_i <= a;
      @(posedge mclk_i);
      unit_acc_i <= 5'h00;
      #1;
      chk({27'h0, unit_done_o}, {27'h0, flt ? 5'h00 : a});
      chk({27'h0, unit_fault_o}, {27'h0, flt ? a : 5'h00});
   endtask : acc
   // enables lag the registers, so let a few edges pass first
   task automatic gates(input logic [4:0] en, input logic [3:0] rate);
      repeat (3) @(posedge mclk_i);
      #1;
      chk({27'h0, unit_clk_en_o}, {27'h0, en});
      chk({28'h0, adc_rate_limit_o}, {28'h0, rate});
   endtask : gates
   task automatic ps(input logic [1:0] s);
      @(posedge mclk_i);
      pstate_i <= s;
   endtask : ps
   task automatic final_report;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   // ==========================================================
   // tests
   initial begin
      repeat (20) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      rd(dscg_pkg::DEEP_GATE_OFS, 32'h00000040);
      rd(dscg_pkg::RUN_GATE_OFS, 32'h00000040);
      rd(dscg_pkg::SLEEP_GATE_OFS, 32'h00000040);
      rd(dscg_pkg::RUN_CFG_OFS, 32'h00000000);
      rd(12'h7FC, 32'h00000000);
      gates(5'h02, 4'h0);
      acc(5'h01, 1'b1);
      acc(5'h02, 1'b0);
      acc(5'h04, 1'b1);
      rd(dscg_pkg::IRQ_STAT_OFS, 32'h00000001);
      chk({31'h0, irq_o}, 32'h00000000);
      wr(dscg_pkg::IRQ_MASK_OFS, 32'h00000003);
      rd(dscg_pkg::IRQ_MASK_OFS, 32'h00000003);
      gates(5'h02, 4'h0);
      chk({31'h0, irq_o}, 32'h00000001);
      wr(dscg_pkg::IRQ_STAT_OFS, 32'h00000001);
      gates(5'h02, 4'h0);
      chk({31'h0, irq_o}, 32'h00000000);
      // fault and clear meet in one edge: the fault must stay flagged
      fork
         acc(5'h01, 1'b1);
         begin
            @(posedge mclk_i);
            wr(dscg_pkg::IRQ_STAT_OFS, 32'h00000001);
         end
      join
      rd(dscg_pkg::IRQ_STAT_OFS, 32'h00000001);
      wr(dscg_pkg::IRQ_STAT_OFS, 32'h00000001);
      // all ones: reserved bits drop, rate above maximum clamps
      wr(dscg_pkg::RUN_GATE_OFS, 32'hFFFFFFFF);
      rd(dscg_pkg::RUN_GATE_OFS, 32'h01110248);
      rd(dscg_pkg::IRQ_STAT_OFS, 32'h00000002);
      wr(dscg_pkg::IRQ_STAT_OFS, 32'h00000002);
      gates(5'h1F, 4'h2);
      acc(5'h1F, 1'b0);
      wr(dscg_pkg::RUN_GATE_OFS, 32'h00000000);
      gates(5'h00, 4'h0);
      acc(5'h1F, 1'b1);
      acc(5'h1F, 1'b1);
      gates(5'h00, 4'h0);
      chk({31'h0, irq_o}, 32'h00000001);
      wr(dscg_pkg::IRQ_STAT_OFS, 32'h00000003);
      // deep set only counts with auto gating on
      wr(dscg_pkg::RUN_GATE_OFS, 32'h00000040);
      ps(2'h2);
      rd(dscg_pkg::PWR_STATE_OFS, 32'h00000002);
      gates(5'h02, 4'h0);
      wr(dscg_pkg::RUN_CFG_OFS, 32'h08000000);
      for (int r = 0; r < 3; r++) begin
         wr(dscg_pkg::DEEP_GATE_OFS, 32'h01000008 | (32'(r) << 8));
         rd(dscg_pkg::DEEP_GATE_OFS, 32'h01000008 | (32'(r) << 8));
         gates(5'h11, 4'(r));
      end
      acc(5'h10, 1'b0);
      acc(5'h02, 1'b1);
      wr(dscg_pkg::SLEEP_GATE_OFS, 32'h00110100);
      ps(2'h1);
      gates(5'h0C, 4'h1);
      wr(dscg_pkg::RUN_CFG_OFS, 32'h00000000);
      gates(5'h02, 4'h0);
      // mid-run reset brings every register back to its reset value
      @(posedge mclk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      rd(dscg_pkg::DEEP_GATE_OFS, 32'h00000040);
      rd(dscg_pkg::RUN_CFG_OFS, 32'h00000000);
      rd(dscg_pkg::IRQ_STAT_OFS, 32'h00000000);
      chk({31'h0, irq_o}, 32'h00000000);
      gates(5'h02, 4'h0);
      final_report;
   end
   initial begin
      #50000;
      failures++;
      final_report;
   end
endmodule : dscg_top_tb
`default_nettype wire
